// file: hw/tbc_pkg.sv
// constants and types for the 64-bit time-base counter
// What this block does
// - a 64-bit count rises by one on each tick and wraps from all ones to zero.
// - wrapping raises no event of any kind.
// - the count is seen as an upper word (big-endian bits 0:31) and a lower word (bits 32:63).
// - a lower-word rollover bumps the upper word in the same tick.
// - reads are allowed in user and privileged mode, writes only in privileged mode.
// - read number 268 returns the lower word and 269 the upper word.
// - privileged write number 284 loads the lower word and 285 the upper word.
// - each access moves one 32-bit word, never the whole count.
// - the tick is the shared interval-timer tick chosen outside the core.
package tbc_pkg;
   localparam int unsigned WORD_WIDTH = 32;
   localparam int unsigned REGN_WIDTH = 10;
   localparam logic [9:0] REGN_LOW_READ   = 10'h10C;
   localparam logic [9:0] REGN_HIGH_READ  = 10'h10D;
   localparam logic [9:0] REGN_LOW_WRITE  = 10'h11C;
   localparam logic [9:0] REGN_HIGH_WRITE = 10'h11D;
   localparam logic [31:0] WORD_RESET = 32'h00000000;

   typedef struct packed {
      logic        read;
      logic        write;
      logic        privileged;
      logic [9:0]  time_base_reg_number;
      logic [31:0] data;
   } tbc_req_t;
endpackage : tbc_pkg

// file: hw/tbc_time_base.sv
// 64-bit time-base counter with split word access
`timescale 1ns/10ps
`default_nettype none
module tbc_time_base
(
   input  wire logic          i_clock,
   input  wire logic          i_rstn,
   input  wire logic          i_tick,
   input  wire tbc_pkg::tbc_req_t i_req,
   output var  logic [31:0]   o_rdata,
   output var  logic          o_rvalid,
   output var  logic          o_refused,
   output var  logic [31:0]   o_time_base_high_word,
   output var  logic [31:0]   o_time_base_low_word
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] high_word;
   logic [31:0] low_word;

   // number match, shared by all four decodes
   function automatic logic regn_is
   (
      input tbc_pkg::tbc_req_t req,
      input logic [9:0]        regn
   );
      return req.time_base_reg_number == regn;
   endfunction : regn_is

   wire         hit_low_rd  = i_req.read
                  && regn_is(i_req, tbc_pkg::REGN_LOW_READ);
   wire         hit_high_rd = i_req.read
                  && regn_is(i_req, tbc_pkg::REGN_HIGH_READ);
   // writes need privilege; user writes are dropped
   wire         wr_ok       = i_req.write && i_req.privileged;
   wire         wr_low      = wr_ok
                  && regn_is(i_req, tbc_pkg::REGN_LOW_WRITE);
   wire         wr_high     = wr_ok
                  && regn_is(i_req, tbc_pkg::REGN_HIGH_WRITE);
   wire         wr_unpriv   = i_req.write && !i_req.privileged;
   // rollover carries silently, no event output exists
   wire         low_carry   = i_tick && (low_word == 32'hFFFFFFFF);
   // write wins over tick for its own word only
   wire [31:0]  next_low    = wr_low ? i_req.data
                  : (i_tick ? low_word + 32'h00000001 : low_word);
   wire [31:0]  next_high   = wr_high ? i_req.data
                  : (low_carry ? high_word + 32'h00000001 : high_word);
   // one word per access
   wire [31:0]  next_rdata  = hit_high_rd ? high_word
                  : (hit_low_rd ? low_word : 32'h00000000);

   ////////////////////////////////////////////////////////////////////////
   // counting runs off the external tick
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         low_word  <= tbc_pkg::WORD_RESET;
         high_word <= tbc_pkg::WORD_RESET;
      end
      else
      begin
         low_word  <= next_low;
         high_word <= next_high;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         o_rdata   <= 32'h00000000;
         o_rvalid  <= 1'b0;
         o_refused <= 1'b0;
         o_time_base_high_word <= 32'h00000000;
         o_time_base_low_word  <= 32'h00000000;
      end
      else
      begin
         o_rdata   <= next_rdata;
         o_rvalid  <= hit_low_rd || hit_high_rd;
         o_refused <= wr_unpriv;
         // upper word is big-endian bits 0:31
         o_time_base_high_word <= next_high;
         o_time_base_low_word  <= next_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_CARRY:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (low_carry && !wr_high && !wr_low)
         |=> (high_word == $past(high_word) + 32'h00000001)
            && (low_word == 32'h00000000))
      else $error("upper word missed the carry");

   AST_COUNT:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (i_tick && !wr_low)
         |=> low_word == $past(low_word) + 32'h00000001)
      else $error("lower word did not count");

   AST_HOLD:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (!i_tick && !i_req.write)
         |=> $stable(low_word) && $stable(high_word))
      else $error("count moved without tick");

   AST_NOUSERWR:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (i_req.write && !i_req.privileged && !i_tick)
         |=> $stable(low_word) && $stable(high_word) && o_refused)
      else $error("user write changed count");

   AST_RDLOW:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         hit_low_rd
         |=> o_rvalid && (o_rdata == $past(low_word)))
      else $error("low read wrong");

   AST_RDHIGH:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         hit_high_rd
         |=> o_rvalid && (o_rdata == $past(high_word)))
      else $error("high read wrong");

   // a low write at all ones with a tick still carries upward
   AST_WRLOW:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (wr_low && !wr_high)
         |=> (low_word == $past(i_req.data))
            && (high_word == $past(high_word)
               + {31'h00000000, $past(low_carry)}))
      else $error("low write touched upper word");

   AST_WRHIGH:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         wr_high
         |=> high_word == $past(i_req.data))
      else $error("high write lost");

   AST_RDNONE:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (!hit_low_rd && !hit_high_rd)
         |=> !o_rvalid && (o_rdata == 32'h00000000))
      else $error("read answer without a read");

   AST_REFUSEPULSE:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         1'b1
         |=> o_refused == $past(wr_unpriv))
      else $error("refusal flag out of step");

   AST_OUTHIGH:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         1'b1
         |-> o_time_base_high_word == high_word)
      else $error("upper word output differs");

   AST_OUTLOW:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         1'b1
         |-> o_time_base_low_word == low_word)
      else $error("lower word output differs");

   // upper word moves only on carry or its own write
   AST_HIGHQUIET:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (!low_carry && !wr_high)
         |=> $stable(high_word))
      else $error("upper word moved without cause");

   // full rollover lands on zero and nothing else happens
   AST_WRAP:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (low_carry && (high_word == 32'hFFFFFFFF) && !wr_high && !wr_low)
         |=> (high_word == 32'h00000000) && (low_word == 32'h00000000))
      else $error("count did not wrap to zero");

   AST_WRLOWTICK:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         wr_low
         |=> low_word == $past(i_req.data))
      else $error("tick beat a low write");

   // read numbers and stray numbers never load the count
   AST_NOSTRAYWR:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         (!wr_low && !wr_high && !i_tick)
         |=> $stable(low_word) && $stable(high_word))
      else $error("count loaded by a foreign number");

   AST_RVPULSE:
      assert property (@(posedge i_clock) disable iff (!i_rstn)
         o_rvalid
         |-> $past(hit_low_rd) || $past(hit_high_rd))
      else $error("read answer without its request");
endmodule : tbc_time_base
`default_nettype wire

// file: verif/tbc_time_base_tb_top.sv
// self-checking bench for the 64-bit time-base counter
`timescale 1ns/10ps
`default_nettype none
module tbc_time_base_tb_top;
   logic              i_clock = 1'b0;
   logic              i_rstn  = 1'b0;
   logic              i_tick  = 1'b0;
   tbc_pkg::tbc_req_t i_req   = '0;
   logic [31:0]       o_rdata, o_time_base_high_word, o_time_base_low_word;
   logic              o_rvalid, o_refused, e_rv = 1'b0, e_rf = 1'b0;
   logic [31:0]       e_rd = '0;
   longint unsigned   m = 0;
   int                n_mismatch = 0, num_checks = 0, cyc = 0;
   logic [15:0]       lf = 16'h0005;
   logic [9:0]        num [5] = '{10'h10C, 10'h10D, 10'h11C, 10'h11D, 10'h000};
   wire logic [9:0]   rn = i_req.time_base_reg_number;
   tbc_time_base tbc_time_base_i (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_tick(i_tick), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
      .o_refused(o_refused), .o_time_base_high_word(o_time_base_high_word),
      .o_time_base_low_word(o_time_base_low_word));
   always #50 i_clock = ~i_clock;
   ////////////////////////////////////////////////////////////////////////////
   // model: old count answers reads, then tick, then writes win their word
   always @(posedge i_clock)
   begin
      e_rv = i_rstn & i_req.read & (rn[9:1] == 9'h086);
      e_rd = !e_rv ? 32'h0 : rn[0] ? m[63:32] : m[31:0];
      e_rf = i_rstn & i_req.write & !i_req.privileged;
      if (i_tick) m = m + 1;
      if (i_req.write & i_req.privileged & rn == 10'h11C) m[31:0] = i_req.data;
      if (i_req.write & i_req.privileged & rn == 10'h11D) m[63:32] = i_req.data;
      if (!i_rstn) m = 0;
      cyc++;
      if (cyc == 4000) begin n_mismatch++; final_report(); end
   end
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin n_mismatch++; $display("unexpected %s exp %h got %h", s, e, g); end
   endtask : chk
   task automatic step(logic t, r, w, p, logic [9:0] n, logic [31:0] d);
      @(negedge i_clock);
      chk("high", m[63:32], o_time_base_high_word);
      chk("low", m[31:0], o_time_base_low_word);
      chk("rvalid", 32'(e_rv), 32'(o_rvalid));
      chk("rdata", e_rd, o_rdata);
      chk("refused", 32'(e_rf), 32'(o_refused));
      i_tick = t;
      i_req = '{r, w, p, n, d};
   endtask : step
   function automatic logic [15:0] nx(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nx
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int k;
      repeat (2) step(0, 0, 0, 0, 10'h0, 0);
      i_rstn = 1'b1;
      step(0, 0, 1, 1, 10'h11C, 0);
      step(0, 0, 1, 1, 10'h11D, 32'hFFFFFFFF);
      step(0, 0, 1, 1, 10'h11C, 32'hFFFFFFFE);
      repeat (3) step(1, 0, 0, 0, 10'h0, 0);
      step(0, 1, 0, 0, 10'h10D, 0);
      step(0, 1, 0, 0, 10'h10C, 0);
      step(0, 1, 0, 0, 10'h10D, 0);
      $display("test wrap and paired access done");
      // unknown numbers always privileged: refusal there is left open
      repeat (2000)
      begin
         lf = nx(lf);
         k = lf[6:4] % 5;
         step(lf[0], lf[1], lf[2], lf[3] | (k == 4), num[k], {lf, nx(lf)});
      end
      $display("test random traffic done");
      final_report();
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
endmodule : tbc_time_base_tb_top
`default_nettype wire
